// file: logic/quad_dac_pkg.sv
// Constants and carrier types shared by the converter update control
//
// Overview of operation
// - Status bits 4..7 show channel A..D power state, 1 when powered up.
// - Current limit off: channel A over-current powers it down, power bit reads 0.
// - Status bits 0..3 flag over-current on channels A..D; read-only, reset zero.
// - Timer mode update interval is (24-bit preload + 1) times ten microseconds.
// - Clear register holds one bit per converter; a set bit asserts its clear.
// - Clear forces all four channels to the converter's clear-select value.
// - Load bits 7..0 act only in manual mode, ignored in other modes.
// - A load bit logs a request; update waits until pending data is transferred.
// - Global manual converters update together once all of them are ready.
// - A load bit clears itself when its outputs are actually updated.
// - Outside timer mode, written channel data is forwarded at once, without waiting for a request.
// - Mode field: 000 instant, 001 manual, 011 timer; other codes reserved.
// - Status mirror refreshes only on a requested read or automatic status read.
// - Each sequencer has a start bit in global control; running means busy.
package quad_dac_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h40;
	localparam logic [7:0] OFS_PRELOAD = 8'h60;
	localparam logic [7:0] OFS_CLEAR = 8'h80;
	localparam logic [7:0] OFS_LOAD = 8'h84;
	localparam logic [7:0] OFS_GCTRL = 8'h88;
	localparam logic [7:0] OFS_GSTAT = 8'h8c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h94;

	// Control register field positions
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_GLOBAL_BIT = 3;
	localparam int CTL_CURRENT_LIMIT_ENABLE_BIT = 4;
	localparam int CTL_CLEAR_VALUE_SELECT_BIT = 5;
	localparam int CTL_ASR_BIT = 6;
	localparam int CTL_STATUS_READ_REQUEST_BIT = 7;
	localparam int CTL_WIDTH = 7;

	// Mode field encodings
	localparam logic [2:0] MODE_INSTANT = 3'h0;
	localparam logic [2:0] MODE_MANUAL = 3'h1;
	localparam logic [2:0] MODE_TIMER = 3'h3;

	// Field widths and reset values
	localparam int PRELOAD_WIDTH = 24;
	localparam int IRQ_WIDTH = 16;
	localparam int IRQ_OC_LSB = 8;
	localparam logic [23:0] PRELOAD_RESET = 24'h000000;

	// Timing
	localparam int CLK_MHZ = 25;
	localparam int TICK_US = 10;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

	// Per-converter configuration
	typedef struct packed {
		logic auto_status_read;
		logic clear_value_select;
		logic current_limit_enable;
		logic global_manual;
		logic [2:0] mode;
	} dac_ctrl_s;

	// Status word as reported by one converter
	typedef struct packed {
		logic thermal_alert;
		logic reference_powered;
		logic chan_d_powered;
		logic chan_c_powered;
		logic chan_b_powered;
		logic chan_a_powered;
		logic chan_d_overcurrent;
		logic chan_c_overcurrent;
		logic chan_b_overcurrent;
		logic chan_a_overcurrent;
	} conv_status_s;

	// Mirrored status with its valid flag
	typedef struct packed {
		logic status_valid;
		conv_status_s status;
	} status_mirror_s;

endpackage

// file: logic/quad_dac_update_control.sv
// Register file and update sequencing for the quad converter board
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module quad_dac_update_control import quad_dac_pkg::*; #(
	parameter int NUM_DACS = 8,
	parameter int TICK_LEN = TICK_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// From the converter transfer logic
	input wire logic [NUM_DACS-1:0] data_pending,
	input wire logic [NUM_DACS-1:0] status_valid,
	input wire conv_status_s [NUM_DACS-1:0] status_data,
	// To the converter transfer logic
	output logic [NUM_DACS-1:0] xfer_enable,
	output logic [NUM_DACS-1:0] transfer_start,
	output logic [NUM_DACS-1:0] status_read_start,
	output logic [NUM_DACS-1:0] dac_update,
	output logic [NUM_DACS-1:0] dac_clear,
	output logic [NUM_DACS-1:0] clear_value_select,
	output logic [NUM_DACS-1:0] current_limit_enable,
	// Interrupt
	output logic irq
);

	dac_ctrl_s ctrl [NUM_DACS];
	status_mirror_s mirror [NUM_DACS];
	logic [PRELOAD_WIDTH-1:0] preload [NUM_DACS];
	logic [NUM_DACS-1:0] clear_bits;
	logic [NUM_DACS-1:0] load_bits;
	logic [NUM_DACS-1:0] seq_run;
	logic [NUM_DACS-1:0] read_wait;
	logic [NUM_DACS-1:0] fire;
	logic [IRQ_WIDTH-1:0] irq_status;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [15:0] tick_count;
	logic tick;
	logic access;
	logic wr;
	logic rd;
	logic [31:0] next_rdata;
	logic next_err;
	logic [NUM_DACS-1:0] is_manual;
	logic [NUM_DACS-1:0] is_global;
	logic [NUM_DACS-1:0] ready;
	logic [NUM_DACS-1:0] next_update;
	logic [NUM_DACS-1:0] status_read_request_req;
	logic [NUM_DACS-1:0] next_read_start;
	logic [NUM_DACS-1:0] oc_event;
	logic global_fire;

	initial begin
		if (NUM_DACS < 1 || NUM_DACS > 8) begin
			$error("quad_dac_update_control: NUM_DACS must be 1..8");
		end
		if (TICK_LEN < 1 || TICK_LEN > 65535) begin
			$error("quad_dac_update_control: TICK_LEN out of range");
		end
	end

	// Converter index from the word address
	function automatic int dac_index(input logic [7:0] addr);
		return int'(addr[4:2]);
	endfunction

	// True when an address targets a per-converter register block
	function automatic logic hits(input logic [7:0] addr,
			input logic [7:0] base);
		return (addr[7:5] == base[7:5]) && (addr[1:0] == 2'h0) &&
			(dac_index(addr) < NUM_DACS);
	endfunction

	// Control word layout as seen on the bus
	function automatic logic [31:0] ctrl_word(input dac_ctrl_s c);
		logic [31:0] w;
		w = '0;
		w[CTL_MODE_LSB +: 3] = c.mode;
		w[CTL_GLOBAL_BIT] = c.global_manual;
		w[CTL_CURRENT_LIMIT_ENABLE_BIT] = c.current_limit_enable;
		w[CTL_CLEAR_VALUE_SELECT_BIT] = c.clear_value_select;
		w[CTL_ASR_BIT] = c.auto_status_read;
		return w;
	endfunction

	// Access strobes: reads decode before pready, writes land with it
	assign access = psel && penable && !pready;
	assign wr = psel && penable && pready && pwrite && !next_err;
	assign rd = access && !pwrite && !next_err;

	// Read mux and address decode
	always_comb begin
		next_rdata = '0;
		next_err = 1'b0;
		if (hits(paddr, OFS_CONTROL)) begin
			next_rdata = ctrl_word(ctrl[dac_index(paddr)]);
		end else if (hits(paddr, OFS_STATUS)) begin
			next_rdata[10:0] = mirror[dac_index(paddr)];
		end else if (hits(paddr, OFS_PRELOAD)) begin
			next_rdata[PRELOAD_WIDTH-1:0] = preload[dac_index(paddr)];
		end else begin
			case (paddr)
				OFS_CLEAR: next_rdata[NUM_DACS-1:0] = clear_bits;
				OFS_LOAD: next_rdata[NUM_DACS-1:0] = load_bits;
				OFS_GCTRL: next_rdata[NUM_DACS-1:0] = seq_run;
				OFS_GSTAT: next_rdata[NUM_DACS-1:0] =
					seq_run | load_bits | data_pending;
				OFS_IRQ_STATUS: next_rdata[IRQ_WIDTH-1:0] = irq_status;
				OFS_IRQ_MASK: next_rdata[IRQ_WIDTH-1:0] = irq_mask;
				default: next_err = 1'b1;
			endcase
		end
	end

	// APB answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (access) begin
			pready <= 1'b1;
			pslverr <= next_err;
			prdata <= pwrite ? 32'h00000000 : next_rdata;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Ten microsecond time base
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_count <= '0;
			tick <= 1'b0;
		end else if (tick_count == 16'(TICK_LEN - 1)) begin
			tick_count <= '0;
			tick <= 1'b1;
		end else begin
			tick_count <= tick_count + 16'h0001;
			tick <= 1'b0;
		end
	end

	// Per-converter control and preload registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_DACS; i++) begin
				ctrl[i] <= '0;
				preload[i] <= PRELOAD_RESET;
			end
		end else if (wr) begin
			if (hits(paddr, OFS_CONTROL)) begin
				ctrl[dac_index(paddr)] <= '{
					auto_status_read: pwdata[CTL_ASR_BIT],
					clear_value_select: pwdata[CTL_CLEAR_VALUE_SELECT_BIT],
					current_limit_enable: pwdata[CTL_CURRENT_LIMIT_ENABLE_BIT],
					global_manual: pwdata[CTL_GLOBAL_BIT],
					mode: pwdata[CTL_MODE_LSB +: 3]};
			end
			if (hits(paddr, OFS_PRELOAD)) begin
				preload[dac_index(paddr)] <=
					pwdata[PRELOAD_WIDTH-1:0];
			end
		end
	end

	// Clear and sequencer start bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clear_bits <= '0;
			seq_run <= '0;
		end else if (wr) begin
			if (paddr == OFS_CLEAR) begin
				clear_bits <= pwdata[NUM_DACS-1:0];
			end
			if (paddr == OFS_GCTRL) begin
				seq_run <= pwdata[NUM_DACS-1:0];
			end
		end
	end

	// Mode decode and readiness of logged requests
	always_comb begin
		for (int i = 0; i < NUM_DACS; i++) begin
			is_manual[i] = (ctrl[i].mode == MODE_MANUAL);
			is_global[i] = is_manual[i] && ctrl[i].global_manual;
			ready[i] = load_bits[i] && !data_pending[i];
		end
	end

	// All global manual converters ready at once
	assign global_fire = (|(is_global & load_bits)) &&
		((is_global & ready) == is_global);

	// Which converters update this cycle
	always_comb begin
		for (int i = 0; i < NUM_DACS; i++) begin
			if (is_global[i]) begin
				next_update[i] = global_fire;
			end else if (is_manual[i]) begin
				next_update[i] = ready[i];
			end else if (ctrl[i].mode == MODE_TIMER) begin
				next_update[i] = fire[i] && seq_run[i];
			end else begin
				next_update[i] = 1'b0;
			end
		end
	end

	// Load bits: set by software in manual mode, cleared on update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_bits <= '0;
		end else begin
			for (int i = 0; i < NUM_DACS; i++) begin
				if (wr && paddr == OFS_LOAD && pwdata[i] && is_manual[i]) begin
					load_bits[i] <= 1'b1;
				end else if (next_update[i] || !is_manual[i]) begin
					load_bits[i] <= 1'b0;
				end
			end
		end
	end

	// Sequencer timers, one per converter
	for (genvar g = 0; g < NUM_DACS; g++) begin : gen_timer
		seq_timer #(
			.WIDTH(PRELOAD_WIDTH)
		) u_timer (
			.pclk(pclk),
			.presetn(presetn),
			.tick(tick),
			.run(seq_run[g] && ctrl[g].mode == MODE_TIMER),
			.preload(preload[g]),
			.fire(fire[g])
		);
	end

	// Converter-side strobes and levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_update <= '0;
			transfer_start <= '0;
			xfer_enable <= '0;
			dac_clear <= '0;
			clear_value_select <= '0;
			current_limit_enable <= '0;
		end else begin
			dac_update <= next_update;
			for (int i = 0; i < NUM_DACS; i++) begin
				transfer_start[i] <= next_update[i] &&
					ctrl[i].mode == MODE_TIMER;
				xfer_enable[i] <= ctrl[i].mode != MODE_TIMER;
				clear_value_select[i] <= ctrl[i].clear_value_select;
				current_limit_enable[i] <= ctrl[i].current_limit_enable;
			end
			dac_clear <= clear_bits;
		end
	end

	// Status read requests: by software or automatic on each tick
	always_comb begin
		for (int i = 0; i < NUM_DACS; i++) begin
			status_read_request_req[i] = wr && hits(paddr, OFS_CONTROL) &&
				dac_index(paddr) == i && pwdata[CTL_STATUS_READ_REQUEST_BIT];
			next_read_start[i] = !read_wait[i] && (status_read_request_req[i] ||
				(ctrl[i].auto_status_read && tick));
		end
	end

	// Outstanding status reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_wait <= '0;
			status_read_start <= '0;
		end else begin
			status_read_start <= next_read_start;
			for (int i = 0; i < NUM_DACS; i++) begin
				if (next_read_start[i]) begin
					read_wait[i] <= 1'b1;
				end else if (status_valid[i]) begin
					read_wait[i] <= 1'b0;
				end
			end
		end
	end

	// Status mirror: refreshed only by a requested or automatic status read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_DACS; i++) begin
				mirror[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_DACS; i++) begin
				if (status_valid[i] && read_wait[i]) begin
					mirror[i].status_valid <= 1'b1;
					mirror[i].status <= status_data[i];
					if (status_data[i].chan_a_overcurrent &&
							!ctrl[i].current_limit_enable) begin
						mirror[i].status.chan_a_powered <= 1'b0;
					end
				end else if (status_read_request_req[i] && (ctrl[i].mode ==
						MODE_INSTANT || is_manual[i])) begin
					mirror[i].status_valid <= 1'b0;
				end
			end
		end
	end

	// Over-current events from a fresh status read
	always_comb begin
		for (int i = 0; i < NUM_DACS; i++) begin
			oc_event[i] = status_valid[i] && read_wait[i] &&
				(status_data[i][3:0] != 4'h0);
		end
	end

	// Interrupt status, mask and output; a new event beats a read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq_mask <= '0;
			irq <= 1'b0;
		end else begin
			for (int i = 0; i < IRQ_WIDTH; i++) begin
				if (i < NUM_DACS && dac_update[i]) begin
					irq_status[i] <= 1'b1;
				end else if (i >= IRQ_OC_LSB && i - IRQ_OC_LSB < NUM_DACS &&
						oc_event[(i - IRQ_OC_LSB) % NUM_DACS]) begin
					irq_status[i] <= 1'b1;
				end else if (rd && paddr == OFS_IRQ_STATUS) begin
					irq_status[i] <= 1'b0;
				end
			end
			if (wr && paddr == OFS_IRQ_MASK) begin
				irq_mask <= pwdata[IRQ_WIDTH-1:0];
			end
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule

// file: logic/seq_timer.sv
// Timer-mode sequencer timer for one converter
`timescale 1ns/1ps
module seq_timer import quad_dac_pkg::*; #(
	parameter int WIDTH = PRELOAD_WIDTH
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic tick,
	input wire logic run,
	input wire logic [WIDTH-1:0] preload,
	// Update trigger
	output logic fire
);

	logic [WIDTH-1:0] count;

	initial begin
		if (WIDTH < 1 || WIDTH > 32) begin
			$error("seq_timer: WIDTH out of range");
		end
	end

	// Count ticks down from preload; fire on every (preload + 1)th tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			fire <= 1'b0;
		end else if (!run) begin
			count <= preload;
			fire <= 1'b0;
		end else if (tick) begin
			if (count == '0) begin
				count <= preload;
				fire <= 1'b1;
			end else begin
				count <= count - 1'b1;
				fire <= 1'b0;
			end
		end else begin
			fire <= 1'b0;
		end
	end

endmodule

// file: testbench/dac_partner.sv
// Behavioural model of the eight quad converters
`timescale 1ns/1ps
module dac_partner import quad_dac_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// From the control block
	input wire logic [7:0] xfer_enable,
	input wire logic [7:0] transfer_start,
	input wire logic [7:0] status_read_start,
	input wire logic [7:0] current_limit_enable,
	// Bench stimulus
	input wire logic [7:0] new_data,
	input wire logic [7:0] stall,
	input wire logic [3:0] oc,
	// To the control block
	output logic [7:0] data_pending,
	output logic [7:0] status_valid,
	output conv_status_s [7:0] status_data
);
	logic [7:0] rd_d1;
	conv_status_s word;
	// Pending data drains while forwarding runs and no stall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_pending <= 8'h00;
		end else begin
			data_pending <= new_data | (data_pending &
				~((xfer_enable | transfer_start) & ~stall));
		end
	end
	// Status read answered two cycles after its start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_d1 <= 8'h00;
			status_valid <= 8'h00;
		end else begin
			rd_d1 <= status_read_start;
			status_valid <= rd_d1;
		end
	end
	// Channel A drops power on over-current without limiting
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			word = {2'b01, 3'b111, !(oc[0] && !current_limit_enable[i]),
				oc};
			status_data[i] = status_valid[i] ? word : ~word;
		end
	end
endmodule

// file: testbench/quad_dac_checker_assertions.sv
// Port-level assertions for the converter update control
`timescale 1ns/1ps
module quad_dac_checker import quad_dac_pkg::*; #(
	parameter int NUM_DACS = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Converter side
	input wire logic [NUM_DACS-1:0] xfer_enable,
	input wire logic [NUM_DACS-1:0] status_read_start,
	input wire logic [NUM_DACS-1:0] dac_clear,
	input wire logic [NUM_DACS-1:0] clear_value_select,
	input wire logic [NUM_DACS-1:0] current_limit_enable
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic taken;
	logic done;
	logic ctl_wr;
	// First access cycle, completing edge and converter 0 control writes
	assign taken = psel && penable && !pready;
	assign done = psel && penable && pready;
	assign ctl_wr = done && pwrite && paddr == OFS_CONTROL;
	a_pready_wait: assert property (taken |=> pready)
		else $error("pready missing after access");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_clear_copy: assert property (
		done && pwrite && paddr == OFS_CLEAR |->
		##2 dac_clear == $past(pwdata[NUM_DACS-1:0], 2))
		else $error("clear outputs differ from written value");
	a_cfg_copy: assert property (ctl_wr |-> ##2
		clear_value_select[0] == $past(pwdata[CTL_CLEAR_VALUE_SELECT_BIT], 2) &&
		current_limit_enable[0] == $past(pwdata[CTL_CURRENT_LIMIT_ENABLE_BIT], 2))
		else $error("config copies differ from control write");
	a_xfer_timer: assert property (
		ctl_wr && pwdata[2:0] == MODE_TIMER |-> ##2 !xfer_enable[0])
		else $error("forwarding left on in timer mode");
	a_xfer_other: assert property (
		ctl_wr && pwdata[2:0] != MODE_TIMER |-> ##2 xfer_enable[0])
		else $error("forwarding off outside timer mode");
	a_status_req: assert property (
		ctl_wr && pwdata[CTL_STATUS_READ_REQUEST_BIT] |-> ##[1:3] status_read_start[0])
		else $error("status read not started after request");
	a_status_pulse: assert property (
		status_read_start[0] |=> !status_read_start[0])
		else $error("status read start longer than a pulse");
endmodule
bind quad_dac_update_control quad_dac_checker #(.NUM_DACS(NUM_DACS)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .xfer_enable(xfer_enable),
	.status_read_start(status_read_start), .dac_clear(dac_clear),
	.clear_value_select(clear_value_select),
	.current_limit_enable(current_limit_enable));

// file: testbench/tb_top.sv
// Self-checking bench for the converter update control
`timescale 1ns/1ps
module tb_top import quad_dac_pkg::*;;
	localparam int TL = 4;
	logic pclk, presetn, psel, penable, pwrite, err, pready, pslverr, irq;
	logic [7:0] paddr, pend, sv, xe, ts, srs, upd, clr, csel, cle, nd, stall;
	logic [31:0] pwdata, prdata, rv;
	logic [3:0] oc;
	conv_status_s [7:0] sd;
	int fail_count, cmp_count, n0, n1, n2, ts_n;
	int upd_n [8];
	time upd_t [8], upd_p [8];
	quad_dac_update_control #(.NUM_DACS(8), .TICK_LEN(TL)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .data_pending(pend),
		.status_valid(sv), .status_data(sd), .xfer_enable(xe),
		.transfer_start(ts), .status_read_start(srs), .dac_update(upd),
		.dac_clear(clr), .clear_value_select(csel),
		.current_limit_enable(cle), .irq(irq));
	dac_partner u_far (.pclk(pclk), .presetn(presetn), .xfer_enable(xe),
		.transfer_start(ts), .status_read_start(srs),
		.current_limit_enable(cle), .new_data(nd), .stall(stall), .oc(oc),
		.data_pending(pend), .status_valid(sv), .status_data(sd));
	// 25 MHz clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Update pulse log per converter
	always @(posedge pclk) begin
		for (int i = 0; i < 8; i++) begin
			if (upd[i] === 1'b1) begin
				upd_p[i] = upd_t[i];
				upd_t[i] = $time;
				upd_n[i]++;
			end
		end
		// Timer transfer starts of converter 3
		if (ts[3] === 1'b1) begin
			ts_n++;
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		xfer(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), rv & m, e);
	endtask
	task automatic wt(input int i, input int n);
		for (int k = 0; k < 200 && upd_n[i] == n; k++) @(posedge pclk);
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge pclk);
		nd <= v;
		@(posedge pclk);
		nd <= 8'h00;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		summarize();
	end
	// Test sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, nd, stall, oc} = '0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STATUS, 32'h0, '1);
		rd(OFS_PRELOAD, 32'h0, '1);
		rd(OFS_CLEAR, 32'h0, '1);
		rd(OFS_LOAD, 32'h0, '1);
		xfer(8'h00, 1'b0, 32'h0);
		chk("unmapped error", err, 1'b1);
		xfer(OFS_PRELOAD, 1'b1, 32'h00abcdef);
		rd(OFS_PRELOAD, 32'h00abcdef, '1);
		$display("registers done");
		xfer(OFS_CLEAR, 1'b1, 32'ha5);
		rd(OFS_CLEAR, 32'ha5, '1);
		chk("dac_clear", clr, 8'ha5);
		xfer(OFS_CONTROL, 1'b1, 32'h20);
		repeat (2) @(posedge pclk);
		chk("clear select", csel[0], 1'b1);
		xfer(OFS_CLEAR, 1'b1, 32'h0);
		xfer(OFS_LOAD, 1'b1, 32'h1);
		rd(OFS_LOAD, 32'h0, '1);
		$display("clear done");
		xfer(OFS_CONTROL, 1'b1, 32'h1);
		chk("forwarding", xe[0], 1'b1);
		stall <= 8'h01;
		pulse(8'h01);
		n0 = upd_n[0];
		xfer(OFS_LOAD, 1'b1, 32'h1);
		rd(OFS_LOAD, 32'h1, '1);
		chk("early update", upd_n[0], n0);
		stall <= 8'h00;
		wt(0, n0);
		chk("update count", upd_n[0], n0 + 1);
		rd(OFS_LOAD, 32'h0, '1);
		chk("irq masked", irq, 1'b0);
		xfer(OFS_IRQ_MASK, 1'b1, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq raised", irq, 1'b1);
		rd(OFS_IRQ_STATUS, 32'h1, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq cleared", irq, 1'b0);
		$display("manual done");
		xfer(OFS_CONTROL + 8'h4, 1'b1, 32'h9);
		xfer(OFS_CONTROL + 8'h8, 1'b1, 32'h9);
		stall <= 8'h04;
		pulse(8'h04);
		n1 = upd_n[1];
		n2 = upd_n[2];
		xfer(OFS_LOAD, 1'b1, 32'h6);
		repeat (20) @(posedge pclk);
		chk("global wait", upd_n[1], n1);
		stall <= 8'h00;
		wt(1, n1);
		wt(2, n2);
		chk("global together", 32'(upd_t[1] == upd_t[2]), 1);
		rd(OFS_LOAD, 32'h0, '1);
		$display("global done");
		xfer(OFS_CONTROL, 1'b1, 32'h3);
		xfer(OFS_PRELOAD + 8'hc, 1'b1, 32'h1);
		xfer(OFS_CONTROL + 8'hc, 1'b1, 32'h3);
		xfer(OFS_GCTRL, 1'b1, 32'h8);
		chk("timer forwarding", xe[0], 1'b0);
		n0 = upd_n[3];
		wt(3, n0);
		wt(3, n0 + 1);
		chk("timer period", 32'((upd_t[3] - upd_p[3]) / 40), 2 * TL);
		rd(OFS_GSTAT, 32'h8, 32'h8);
		xfer(OFS_LOAD, 1'b1, 32'h8);
		rd(OFS_LOAD, 32'h0, 32'h8);
		xfer(OFS_GCTRL, 1'b1, 32'h0);
		chk("timer starts", ts_n, upd_n[3]);
		$display("timer done");
		oc <= 4'h1;
		xfer(OFS_CONTROL, 1'b1, 32'h81);
		repeat (8) @(posedge pclk);
		rd(OFS_STATUS, 32'h5e1, '1);
		rd(OFS_IRQ_STATUS, 32'h100, 32'h100);
		xfer(OFS_CONTROL, 1'b1, 32'h91);
		repeat (8) @(posedge pclk);
		rd(OFS_STATUS, 32'h5f1, '1);
		oc <= 4'h0;
		repeat (20) @(posedge pclk);
		rd(OFS_STATUS, 32'h5f1, '1);
		$display("status done");
		summarize();
	end
endmodule
